// ### verilog/hpdpu_map.vh
`ifndef HPDPU_MAP_VH
`define HPDPU_MAP_VH

// Operand formats
`define HPDPU_FMT_FLUSH 2'h0
`define HPDPU_FMT_EXT 2'h1
`define HPDPU_FMT_BF 2'h2

// Operating modes
`define HPDPU_MODE_SUM2 2'h0
`define HPDPU_MODE_ADD 2'h1
`define HPDPU_MODE_ACC 2'h2
`define HPDPU_MODE_VEC1 2'h3

// Field widths of the internal 1.8.10 and single layouts
`define HPDPU_OP_W 19
`define HPDPU_SP_W 32
`define HPDPU_EXP_W 8
`define HPDPU_MAN_W 10
`define HPDPU_SP_MAN_W 23

// Exponent handling, biased 8-bit values
`define HPDPU_BIAS 11'h07f
`define HPDPU_REBIAS 8'h70
`define HPDPU_HALF_SUB_EXP 8'h71
`define HPDPU_FLUSH_EXP_HI 8'h8e
`define HPDPU_FLUSH_EXP_LO 8'h71
`define HPDPU_WIDE_EXP_HI 8'hfe
`define HPDPU_WIDE_EXP_LO 8'h01
`define HPDPU_EXP_ALL 8'hff
`define HPDPU_QNAN_FRAC 10'h200
`define HPDPU_WIDEN_PAD 13'h0000

`endif

// ### verilog/hpdpu_fp_add.v
`timescale 1ns/1ps
module hpdpu_fp_add #(
    parameter EW = 8,
    parameter MW = 10
) (
    input wire [EW+MW:0] a,
    input wire [EW+MW:0] b,
    input wire sub,
    input wire rz,
    input wire qnanInv,
    input wire [EW-1:0] expLo,
    input wire [EW-1:0] expHi,
    output reg [EW+MW:0] res,
    output reg invalid,
    output reg inexact,
    output reg overflow,
    output reg underflow
);
    localparam W = MW + 5;
    localparam N = EW + MW;
    localparam signed [EW+1:0] ONE = 1;
    reg sa, sb, sx, sy, aNan, bNan, aInf, bInf, swap, g, st, rnd;
    reg [EW-1:0] ex, ey, d;
    reg [W-1:0] big, minor, sum;
    reg [MW:0] m;
    reg signed [EW+1:0] e;
    integer i;

    always @* begin
        sa = a[N];
        sb = b[N] ^ sub;
        aNan = &a[N-1:MW] && |a[MW-1:0];
        bNan = &b[N-1:MW] && |b[MW-1:0];
        aInf = &a[N-1:MW] && !(|a[MW-1:0]);
        bInf = &b[N-1:MW] && !(|b[MW-1:0]);
        swap = b[N-1:0] > a[N-1:0];
        sx = swap ? sb : sa;
        sy = swap ? sa : sb;
        ex = swap ? b[N-1:MW] : a[N-1:MW];
        ey = swap ? a[N-1:MW] : b[N-1:MW];
        // Zero exponent is zero: no subnormal enters the sum [RULE4]
        big = (ex == 0) ? {W{1'b0}} : {2'b01, (swap ? b[MW-1:0] : a[MW-1:0]), 3'b000};
        minor = (ey == 0) ? {W{1'b0}} : {2'b01, (swap ? a[MW-1:0] : b[MW-1:0]), 3'b000};
        d = ex - ey;
        minor = (minor >> d) | {{(W-1){1'b0}}, |(minor & ~({W{1'b1}} << d))};
        sum = (sx != sy) ? big - minor : big + minor;
        e = $signed({2'b00, ex});
        if (sum[W-1]) begin
            sum = {1'b0, sum[W-1:2], sum[1] | sum[0]};
            e = e + ONE;
        end
        // Deep shifts only follow near cancellation, where no bit was lost
        for (i = 0; i < W; i = i + 1) begin
            if (!sum[W-2] && sum != 0) begin
                sum = sum << 1;
                e = e - ONE;
            end
        end
        g = sum[2];
        st = sum[1] | sum[0];
        rnd = !rz && g && (st || sum[3]); // [RULE8] [RULE9]
        m = {1'b0, sum[W-3:3]} + {{MW{1'b0}}, rnd};
        if (m[MW]) begin
            e = e + ONE;
        end
        inexact = g || st;
        overflow = 1'b0;
        underflow = 1'b0;
        invalid = 1'b0;
        if (sum == 0) begin
            res = {sx & sy, {N{1'b0}}};
        end else if (e > $signed({2'b00, expHi})) begin
            overflow = 1'b1;
            inexact = 1'b1;
            res = rz ? {sx, expHi, {MW{1'b1}}} : {sx, {EW{1'b1}}, {MW{1'b0}}};
        end else if (e < $signed({2'b00, expLo})) begin
            underflow = 1'b1; // [RULE4]
            inexact = 1'b1;
            res = {sx, {N{1'b0}}};
        end else begin
            res = {sx, e[EW-1:0], m[MW-1:0]};
        end
        if (aNan || bNan) begin
            res = {1'b0, {EW{1'b1}}, 1'b1, {(MW-1){1'b0}}};
            invalid = (aNan && !a[MW-1]) || (bNan && !b[MW-1]) || qnanInv; // [RULE7]
            inexact = 1'b0;
            overflow = 1'b0;
            underflow = 1'b0;
        end else if (aInf && bInf && sa != sb) begin
            res = {1'b0, {EW{1'b1}}, 1'b1, {(MW-1){1'b0}}};
            invalid = 1'b1; // [RULE7]
            inexact = 1'b0;
            overflow = 1'b0;
            underflow = 1'b0;
        end else if (aInf || bInf) begin
            res = {aInf ? sa : sb, {EW{1'b1}}, {MW{1'b0}}};
            inexact = 1'b0;
            overflow = 1'b0;
            underflow = 1'b0;
        end
    end
endmodule // hpdpu_fp_add

// ### verilog/hpdpu_dot_unit.v
// Notes on behaviour
// RULE1 - Flushed takes and computes 1.5.10 half values
// RULE2 - Extended widens products and sums to 1.8.10
// RULE3 - Bfloat operands are 1.8.7 or 19-bit 1.8.10
// RULE4 - Flushed and bfloat replace subnormal results by zero
// RULE5 - Extended keeps half subnormals as wide normals
// RULE6 - Extended half flags: infinite, zero, inexact, invalid
// RULE7 - Invalid on ill-defined ops; extended also qNaN
// RULE8 - Flushed rounds nearest even, bfloat toward zero
// RULE9 - Extended: normal products, sums nearest even
// RULE10 - One subnormal operand: round by mantissa product
// RULE11 - Every mode runs in all three formats
// RULE12 - Sum of two products gives single result
// RULE13 - Addend input added to product sum
// RULE14 - Accumulate adds products to previous result
// RULE15 - Vector one without cascade; addend to cascade out
// RULE16 - Vector one with cascade adds or subtracts it
// RULE17 - Flushed/bfloat flag overflow, underflow, inexact, invalid
// RULE18 - Extended half flags; single adder keeps four flags
// RULE19 - Driver holds accumulate high to accumulate
// RULE20 - Flags travel aligned with their result
// RULE21 - Format, cascade and subtract are build-time settings
// RULE22 - Clear zeroes pipeline, accumulator and flags
`timescale 1ns/1ps
`include "hpdpu_map.vh"
module hpdpu_dot_unit #(
    parameter [1:0] FORMAT = `HPDPU_FMT_EXT,
    parameter [1:0] MODE = `HPDPU_MODE_SUM2,
    parameter BF_WIDE = 0,
    parameter CASCADE_EN = 0,
    parameter SUBTRACT = 0
) (
    input wire clk,
    input wire rst,
    input wire clear,
    input wire accumulate,
    input wire [18:0] upper_pair_operand_x,
    input wire [18:0] upper_pair_operand_y,
    input wire [18:0] lower_pair_operand_x,
    input wire [18:0] lower_pair_operand_y,
    input wire [31:0] single_addend_in,
    input wire [31:0] cascade_value_in,
    output reg [31:0] single_result_out,
    output reg [31:0] cascade_value_out,
    output reg upper_product_invalid_flag,
    output reg upper_product_inexact_flag,
    output reg upper_product_overflow_flag,
    output reg upper_product_underflow_flag,
    output reg upper_product_infinite_flag,
    output reg upper_product_zero_flag,
    output reg lower_product_invalid_flag,
    output reg lower_product_inexact_flag,
    output reg lower_product_overflow_flag,
    output reg lower_product_underflow_flag,
    output reg lower_product_infinite_flag,
    output reg lower_product_zero_flag,
    output reg half_sum_invalid_flag,
    output reg half_sum_inexact_flag,
    output reg half_sum_overflow_flag,
    output reg half_sum_underflow_flag,
    output reg half_sum_infinite_flag,
    output reg half_sum_zero_flag,
    output reg single_sum_invalid_flag,
    output reg single_sum_inexact_flag,
    output reg single_sum_overflow_flag,
    output reg single_sum_underflow_flag
);
    // Settings are parameters so they cannot move while running [RULE21] [RULE11]
    localparam [0:0] IS_EXT = (FORMAT == `HPDPU_FMT_EXT);
    localparam [0:0] IS_BF = (FORMAT == `HPDPU_FMT_BF);
    localparam [0:0] IS_FLUSH = (FORMAT == `HPDPU_FMT_FLUSH);
    localparam [7:0] EXP_HI = IS_FLUSH ? `HPDPU_FLUSH_EXP_HI : `HPDPU_WIDE_EXP_HI;
    localparam [7:0] EXP_LO = IS_FLUSH ? `HPDPU_FLUSH_EXP_LO : `HPDPU_WIDE_EXP_LO;
    localparam [0:0] HALF_SUB = (MODE == `HPDPU_MODE_VEC1) && (SUBTRACT != 0);
    localparam [0:0] SINGLE_SUB = HALF_SUB && (CASCADE_EN != 0);

    // Operand to internal 1.8.10 encoding
    function [18:0] toInt(input [18:0] v);
        reg [9:0] f;
        reg [7:0] e;
        integer k;
        begin
            f = v[9:0];
            e = `HPDPU_HALF_SUB_EXP;
            if (IS_BF) begin
                toInt = BF_WIDE ? v : {v[15:0], 3'h0}; // [RULE3]
                if (toInt[17:10] == 8'h00) begin
                    toInt = {toInt[18], 18'h00000}; // [RULE4]
                end
            end else if (v[14:10] == 5'h1f) begin
                toInt = {v[15], `HPDPU_EXP_ALL, v[9:0]};
            end else if (v[14:10] != 5'h00) begin
                toInt = {v[15], {3'h0, v[14:10]} + `HPDPU_REBIAS, v[9:0]}; // [RULE1] [RULE2]
            end else if (IS_EXT && f != 10'h000) begin
                for (k = 0; k < 10; k = k + 1) begin
                    if (!f[9]) begin
                        f = f << 1;
                        e = e - 8'h01;
                    end
                end
                toInt = {v[15], e - 8'h01, f[8:0], 1'b0}; // [RULE5]
            end else begin
                toInt = {v[15], 18'h00000}; // [RULE4]
            end
        end
    endfunction

    function isSub(input [15:0] v);
        begin
            isSub = IS_EXT && v[14:10] == 5'h00 && v[9:0] != 10'h000;
        end
    endfunction

    // Product rounding choice, from the raw significands
    function rzSel(input [15:0] x, input [15:0] y);
        reg [21:0] raw;
        begin
            raw = {|x[14:10], x[9:0]} * {|y[14:10], y[9:0]};
            if (IS_BF) begin
                rzSel = 1'b1; // [RULE8]
            end else if (!IS_EXT) begin
                rzSel = 1'b0; // [RULE8]
            end else if (isSub(x) && isSub(y)) begin
                rzSel = 1'b1; // [RULE9]
            end else if (isSub(x) || isSub(y)) begin
                rzSel = !(raw[21] || raw[20] || (&raw[19:11])); // [RULE10]
            end else begin
                rzSel = 1'b0; // [RULE9]
            end
        end
    endfunction

    // Half product: returns {invalid, inexact, overflow, underflow, value}
    function [22:0] mulOp(input [18:0] a, input [18:0] b, input rz);
        reg s, nA, nB, iA, iB, zA, zB, inv, inx, ovf, unf, g, st;
        reg [21:0] p;
        reg [10:0] m;
        reg signed [10:0] e;
        reg [18:0] r;
        begin
            s = a[18] ^ b[18];
            nA = &a[17:10] && |a[9:0];
            nB = &b[17:10] && |b[9:0];
            iA = &a[17:10] && !(|a[9:0]);
            iB = &b[17:10] && !(|b[9:0]);
            zA = a[17:10] == 8'h00;
            zB = b[17:10] == 8'h00;
            inv = 1'b0;
            ovf = 1'b0;
            unf = 1'b0;
            p = {1'b1, a[9:0]} * {1'b1, b[9:0]};
            e = {3'h0, a[17:10]} + {3'h0, b[17:10]} - `HPDPU_BIAS + {10'h000, p[21]};
            if (p[21]) begin
                m = {1'b0, p[20:11]};
                g = p[10];
                st = |p[9:0];
            end else begin
                m = {1'b0, p[19:10]};
                g = p[9];
                st = |p[8:0];
            end
            m = m + {10'h000, !rz && g && (st || m[0])};
            if (m[10]) begin
                e = e + 11'h001;
            end
            inx = g || st;
            if (e > $signed({3'h0, EXP_HI})) begin
                ovf = 1'b1;
                inx = 1'b1;
                r = rz ? {s, EXP_HI, 10'h3ff} : {s, `HPDPU_EXP_ALL, 10'h000};
            end else if (e < $signed({3'h0, EXP_LO})) begin
                unf = 1'b1; // [RULE4]
                inx = 1'b1;
                r = {s, 18'h00000};
            end else begin
                r = {s, e[7:0], m[9:0]};
            end
            if (nA || nB) begin
                r = {1'b0, `HPDPU_EXP_ALL, `HPDPU_QNAN_FRAC};
                inv = (nA && !a[9]) || (nB && !b[9]) || IS_EXT; // [RULE7]
                {inx, ovf, unf} = 3'h0;
            end else if ((iA && zB) || (iB && zA)) begin
                r = {1'b0, `HPDPU_EXP_ALL, `HPDPU_QNAN_FRAC};
                inv = 1'b1; // [RULE7]
                {inx, ovf, unf} = 3'h0;
            end else if (iA || iB) begin
                r = {s, `HPDPU_EXP_ALL, 10'h000};
                {inx, ovf, unf} = 3'h0;
            end else if (zA || zB) begin
                r = {s, 18'h00000};
                {inx, ovf, unf} = 3'h0;
            end
            mulOp = {inv, inx, ovf, unf, r};
        end
    endfunction

    // Flag set per format: {invalid, inexact, overflow, underflow, infinite, zero}
    function [5:0] flags6(input [22:0] f);
        begin
            if (IS_EXT) begin
                flags6 = {f[22], f[21], 2'h0, &f[17:10] && !(|f[9:0]),
                    f[17:10] == 8'h00}; // [RULE6] [RULE18]
            end else begin
                flags6 = {f[22:19], 2'h0}; // [RULE17]
            end
        end
    endfunction

    reg [22:0] s1Top, s1Bot;
    reg [31:0] s1Add, s2Add;
    reg s1Acc, s2Acc;
    reg [18:0] s2Half;
    reg [5:0] s2TopF, s2BotF, s2HalfF;
    reg [31:0] opB;
    reg use32;
    wire [18:0] halfRes;
    wire hInv, hInx, hOvf, hUnf;
    wire [31:0] sRes;
    wire sInv, sInx, sOvf, sUnf;
    wire [31:0] wideHalf = {s2Half, `HPDPU_WIDEN_PAD};

    // Stage one: both products
    always @(posedge clk) begin
        if (rst || clear) begin
            s1Top <= 23'h000000; // [RULE22]
            s1Bot <= 23'h000000;
            s1Add <= 32'h00000000;
            s1Acc <= 1'b0;
        end else begin
            s1Top <= mulOp(toInt(upper_pair_operand_x), toInt(upper_pair_operand_y),
                rzSel(upper_pair_operand_x[15:0], upper_pair_operand_y[15:0]));
            s1Bot <= mulOp(toInt(lower_pair_operand_x), toInt(lower_pair_operand_y),
                rzSel(lower_pair_operand_x[15:0], lower_pair_operand_y[15:0]));
            s1Add <= single_addend_in;
            s1Acc <= accumulate; // [RULE19]
        end
    end

    hpdpu_fp_add #(
        .EW(`HPDPU_EXP_W),
        .MW(`HPDPU_MAN_W)
    ) halfAdder (
        .a(s1Top[18:0]),
        .b(s1Bot[18:0]),
        .sub(HALF_SUB),
        .rz(IS_BF),
        .qnanInv(IS_EXT),
        .expLo(EXP_LO),
        .expHi(EXP_HI),
        .res(halfRes),
        .invalid(hInv),
        .inexact(hInx),
        .overflow(hOvf),
        .underflow(hUnf)
    ); // [RULE12] [RULE15]

    // Stage two: half sum, product flags carried along
    always @(posedge clk) begin
        if (rst || clear) begin
            s2Half <= 19'h00000; // [RULE22]
            s2TopF <= 6'h00;
            s2BotF <= 6'h00;
            s2HalfF <= 6'h00;
            s2Add <= 32'h00000000;
            s2Acc <= 1'b0;
        end else begin
            s2Half <= halfRes;
            s2TopF <= flags6(s1Top); // [RULE20]
            s2BotF <= flags6(s1Bot);
            s2HalfF <= flags6({hInv, hInx, hOvf, hUnf, halfRes});
            s2Add <= s1Add;
            s2Acc <= s1Acc;
        end
    end

    // Cascade input is taken here, in step with the final add
    always @* begin
        case (MODE)
            `HPDPU_MODE_ADD: begin
                opB = s2Add; // [RULE13]
                use32 = 1'b1;
            end
            `HPDPU_MODE_ACC: begin
                opB = single_result_out; // [RULE14]
                use32 = s2Acc; // [RULE19]
            end
            `HPDPU_MODE_VEC1: begin
                opB = cascade_value_in; // [RULE16]
                use32 = (CASCADE_EN != 0);
            end
            default: begin
                opB = 32'h00000000;
                use32 = 1'b0;
            end
        endcase
    end

    hpdpu_fp_add #(
        .EW(`HPDPU_EXP_W),
        .MW(`HPDPU_SP_MAN_W)
    ) singleAdder (
        .a(wideHalf),
        .b(opB),
        .sub(SINGLE_SUB),
        .rz(1'b0),
        .qnanInv(1'b0),
        .expLo(`HPDPU_WIDE_EXP_LO),
        .expHi(`HPDPU_WIDE_EXP_HI),
        .res(sRes),
        .invalid(sInv),
        .inexact(sInx),
        .overflow(sOvf),
        .underflow(sUnf)
    );

    // Output stage: every port from a flop
    always @(posedge clk) begin
        if (rst || clear) begin
            single_result_out <= 32'h00000000; // [RULE22]
            cascade_value_out <= 32'h00000000;
            {upper_product_invalid_flag, upper_product_inexact_flag,
                upper_product_overflow_flag, upper_product_underflow_flag,
                upper_product_infinite_flag, upper_product_zero_flag} <= 6'h00;
            {lower_product_invalid_flag, lower_product_inexact_flag,
                lower_product_overflow_flag, lower_product_underflow_flag,
                lower_product_infinite_flag, lower_product_zero_flag} <= 6'h00;
            {half_sum_invalid_flag, half_sum_inexact_flag, half_sum_overflow_flag,
                half_sum_underflow_flag, half_sum_infinite_flag, half_sum_zero_flag} <= 6'h00;
            {single_sum_invalid_flag, single_sum_inexact_flag, single_sum_overflow_flag,
                single_sum_underflow_flag} <= 4'h0;
        end else begin
            single_result_out <= use32 ? sRes : wideHalf; // [RULE12] [RULE14] [RULE15]
            cascade_value_out <= s2Add; // [RULE15]
            {upper_product_invalid_flag, upper_product_inexact_flag,
                upper_product_overflow_flag, upper_product_underflow_flag,
                upper_product_infinite_flag, upper_product_zero_flag} <= s2TopF; // [RULE20]
            {lower_product_invalid_flag, lower_product_inexact_flag,
                lower_product_overflow_flag, lower_product_underflow_flag,
                lower_product_infinite_flag, lower_product_zero_flag} <= s2BotF;
            {half_sum_invalid_flag, half_sum_inexact_flag, half_sum_overflow_flag,
                half_sum_underflow_flag, half_sum_infinite_flag,
                half_sum_zero_flag} <= s2HalfF;
            // Without a single add stage these stay low [RULE17] [RULE18]
            {single_sum_invalid_flag, single_sum_inexact_flag, single_sum_overflow_flag,
                single_sum_underflow_flag} <= use32 ? {sInv, sInx, sOvf, sUnf} : 4'h0;
        end
    end
endmodule // hpdpu_dot_unit

// ### sim/hpdpu_dot_unit_asserts.sv
`timescale 1ns/1ps
`include "hpdpu_map.vh"
module hpdpu_dot_unit_asserts #(
    parameter [1:0] FORMAT = `HPDPU_FMT_EXT,
    parameter [1:0] MODE = `HPDPU_MODE_SUM2
) (
    input wire clk,
    input wire rst,
    input wire clear,
    input wire accumulate,
    input wire [18:0] upper_pair_operand_x,
    input wire [18:0] upper_pair_operand_y,
    input wire [31:0] single_addend_in,
    input wire [31:0] single_result_out,
    input wire [31:0] cascade_value_out,
    input wire upper_product_invalid_flag,
    input wire upper_product_overflow_flag,
    input wire upper_product_underflow_flag,
    input wire upper_product_infinite_flag,
    input wire upper_product_zero_flag,
    input wire half_sum_overflow_flag,
    input wire half_sum_infinite_flag,
    input wire single_sum_invalid_flag,
    input wire single_sum_inexact_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire extFmt = (FORMAT == `HPDPU_FMT_EXT);
    wire halfIn = (FORMAT != `HPDPU_FMT_BF);
    // Operand decodes hold for the half layouts only
    wire upQnan = (upper_pair_operand_x[14:9] == 6'h3f);
    wire upInf = (upper_pair_operand_x[14:0] == 15'h7c00);
    wire upZero = (upper_pair_operand_x[14:0] == 15'h0000);
    wire yZero = (upper_pair_operand_y[14:0] == 15'h0000);
    wire yOne = (upper_pair_operand_y[15:0] == 16'h3c00);

    clear_zeroes_a: assert property (clear |=> single_result_out == 32'h0
        && cascade_value_out == 32'h0 && !upper_product_invalid_flag && !single_sum_invalid_flag)
        else $error("outputs not zero after clear");
    addend_forward_a: assert property (!clear[*3] |=>
        cascade_value_out == $past(single_addend_in, 3)) else $error("cascade copy wrong");
    ext_no_range_a: assert property (extFmt |-> !upper_product_overflow_flag
        && !upper_product_underflow_flag && !half_sum_overflow_flag)
        else $error("range flag in extended");
    flush_no_inf_a: assert property (!extFmt |-> !upper_product_infinite_flag
        && !upper_product_zero_flag && !half_sum_infinite_flag)
        else $error("infinite or zero flag outside extended");
    no_subnormal_a: assert property (!extFmt && MODE != `HPDPU_MODE_ADD
        && single_result_out[30:23] == 8'h00 |-> single_result_out[22:0] == 23'h0)
        else $error("subnormal result");
    qnan_invalid_a: assert property (extFmt && upQnan && !clear ##1 !clear[*2]
        |=> upper_product_invalid_flag) else $error("quiet nan not invalid");
    inf_zero_invalid_a: assert property (halfIn && upInf && yZero && !clear
        ##1 !clear[*2] |=> upper_product_invalid_flag) else $error("inf times zero valid");
    zero_flag_a: assert property (extFmt && upZero && yOne && !clear ##1 !clear[*2]
        |=> upper_product_zero_flag) else $error("zero product not flagged");
    single_idle_a: assert property ((MODE == `HPDPU_MODE_SUM2
        || (MODE == `HPDPU_MODE_ACC && !accumulate)) && !clear ##1 !clear[*2]
        |=> !single_sum_invalid_flag && !single_sum_inexact_flag)
        else $error("single adder flag while idle");

    cover property (clear);
    cover property (accumulate && !clear);
    cover property (upper_product_invalid_flag);
endmodule // hpdpu_dot_unit_asserts

bind hpdpu_dot_unit hpdpu_dot_unit_asserts #(.FORMAT(FORMAT), .MODE(MODE)) i_asserts (
    .clk(clk), .rst(rst), .clear(clear), .accumulate(accumulate),
    .upper_pair_operand_x(upper_pair_operand_x), .upper_pair_operand_y(upper_pair_operand_y),
    .single_addend_in(single_addend_in), .single_result_out(single_result_out),
    .cascade_value_out(cascade_value_out),
    .upper_product_invalid_flag(upper_product_invalid_flag),
    .upper_product_overflow_flag(upper_product_overflow_flag),
    .upper_product_underflow_flag(upper_product_underflow_flag),
    .upper_product_infinite_flag(upper_product_infinite_flag),
    .upper_product_zero_flag(upper_product_zero_flag),
    .half_sum_overflow_flag(half_sum_overflow_flag),
    .half_sum_infinite_flag(half_sum_infinite_flag),
    .single_sum_invalid_flag(single_sum_invalid_flag),
    .single_sum_inexact_flag(single_sum_inexact_flag));

// ### sim/hpdpu_cascade_model.sv
`timescale 1ns/1ps
// Previous block of the chain; two registers so its value meets the late cascade sample
module hpdpu_cascade_model (
    input wire clk,
    input wire rst,
    input wire [31:0] valueIn,
    output reg [31:0] valueOut
);
    reg [31:0] stage;
    always @(posedge clk) begin
        if (rst) begin
            stage <= 32'h0;
            valueOut <= 32'h0;
        end else begin
            stage <= valueIn;
            valueOut <= stage;
        end
    end
endmodule // hpdpu_cascade_model

// ### sim/hpdpu_dot_unit_bench.sv
`timescale 1ns/1ps
`include "hpdpu_map.vh"
`define CHK(got, exp) begin \
    comparisons = comparisons + 1; \
    if ((got) !== (exp)) begin \
        numErrors = numErrors + 1; \
        $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module hpdpu_dot_unit_bench;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg clear = 1'b0;
    reg acc = 1'b0;
    reg [18:0] ux, uy, lx, ly;
    reg [31:0] addend, casc;
    wire [31:0] cascIn, resA, coutA, resB, coutB;
    wire invA, infA, zeroA, inexA, invB, ovfB, unfB, inexB, hInvA;
    integer numErrors = 0;
    integer comparisons = 0;

    always #50 clk = ~clk;

    hpdpu_cascade_model i_prev (.clk(clk), .rst(rst), .valueIn(casc), .valueOut(cascIn));

    // Extended, vector one, cascade on, subtracting
    hpdpu_dot_unit #(.FORMAT(`HPDPU_FMT_EXT), .MODE(`HPDPU_MODE_VEC1), .CASCADE_EN(1),
        .SUBTRACT(1)) i_dut (.clk(clk), .rst(rst), .clear(clear), .accumulate(acc),
        .upper_pair_operand_x(ux), .upper_pair_operand_y(uy), .lower_pair_operand_x(lx),
        .lower_pair_operand_y(ly), .single_addend_in(addend), .cascade_value_in(cascIn),
        .single_result_out(resA), .cascade_value_out(coutA), .upper_product_invalid_flag(invA),
        .upper_product_inexact_flag(inexA), .upper_product_overflow_flag(),
        .upper_product_underflow_flag(), .upper_product_infinite_flag(infA),
        .upper_product_zero_flag(zeroA), .lower_product_invalid_flag(),
        .lower_product_inexact_flag(), .lower_product_overflow_flag(),
        .lower_product_underflow_flag(), .lower_product_infinite_flag(),
        .lower_product_zero_flag(), .half_sum_invalid_flag(hInvA), .half_sum_inexact_flag(),
        .half_sum_overflow_flag(), .half_sum_underflow_flag(), .half_sum_infinite_flag(),
        .half_sum_zero_flag(), .single_sum_invalid_flag(), .single_sum_inexact_flag(),
        .single_sum_overflow_flag(), .single_sum_underflow_flag());

    // Flushed, accumulating; shares every input with the first instance
    hpdpu_dot_unit #(.FORMAT(`HPDPU_FMT_FLUSH), .MODE(`HPDPU_MODE_ACC)) i_acc (.clk(clk),
        .rst(rst), .clear(clear), .accumulate(acc),
        .upper_pair_operand_x(ux), .upper_pair_operand_y(uy), .lower_pair_operand_x(lx),
        .lower_pair_operand_y(ly), .single_addend_in(addend), .cascade_value_in(cascIn),
        .single_result_out(resB), .cascade_value_out(coutB), .upper_product_invalid_flag(invB),
        .upper_product_inexact_flag(inexB), .upper_product_overflow_flag(ovfB),
        .upper_product_underflow_flag(unfB), .upper_product_infinite_flag(),
        .upper_product_zero_flag(), .lower_product_invalid_flag(),
        .lower_product_inexact_flag(), .lower_product_overflow_flag(),
        .lower_product_underflow_flag(), .lower_product_infinite_flag(),
        .lower_product_zero_flag(), .half_sum_invalid_flag(), .half_sum_inexact_flag(),
        .half_sum_overflow_flag(), .half_sum_underflow_flag(), .half_sum_infinite_flag(),
        .half_sum_zero_flag(), .single_sum_invalid_flag(), .single_sum_inexact_flag(),
        .single_sum_overflow_flag(), .single_sum_underflow_flag());

    task drive(input [15:0] a, input [15:0] b, input [15:0] c, input [15:0] d,
        input [31:0] k);
        @(negedge clk);
        ux = {3'h0, a};
        uy = {3'h0, b};
        lx = {3'h0, c};
        ly = {3'h0, d};
        casc = k;
    endtask

    // Three register stages between operands and outputs
    task settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    task results;
        $display("Comparisons %0d, mismatches %0d", comparisons, numErrors);
        if (numErrors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task t_sum;
        addend = 32'h4120_0000;
        drive(16'h4200, 16'h4000, 16'h3c00, 16'h3c00, 32'h3f80_0000);
        settle;
        `CHK(resA, 32'h4080_0000)
        `CHK(resB, 32'h40e0_0000)
        `CHK(coutA, 32'h4120_0000)
    endtask

    task t_round;
        drive(16'h3e00, 16'h3c01, 16'h0000, 16'h0000, 32'h0);
        settle;
        `CHK(resA, 32'h3fc0_4000)
        `CHK(resB, 32'h3fc0_4000)
        `CHK({inexA, inexB}, 2'b11)
    endtask

    task t_tiny;
        drive(16'h0400, 16'h3800, 16'h0000, 16'h0000, 32'h0);
        settle;
        `CHK(resA, 32'h3800_0000)
        `CHK({resB, unfB}, {32'h0, 1'b1})
    endtask

    task t_flag(input [15:0] a, input [15:0] b, input [5:0] e);
        drive(a, b, 16'h0000, 16'h0000, 32'h0);
        settle;
        `CHK({invA, infA, zeroA, invB, ovfB, hInvA}, e)
    endtask

    task t_accum;
        reg [127:0] sums;
        integer i;
        sums = {32'h4100_0000, 32'h40c0_0000, 32'h4080_0000, 32'h4000_0000};
        for (i = 0; i < 7; i = i + 1) begin
            drive(16'h3c00, 16'h3c00, 16'h3c00, 16'h3c00, 32'h0);
            acc = (i != 0);
            if (i >= 3) begin
                `CHK(resB, sums[32 * (i - 3) +: 32])
            end
        end
        clear = 1'b1;
        @(negedge clk);
        clear = 1'b0;
        `CHK({resB, coutA}, 64'h0)
        settle;
        `CHK(resB, 32'h4000_0000)
        acc = 1'b0;
    endtask

    initial begin
        ux = 19'h0;
        uy = 19'h0;
        lx = 19'h0;
        ly = 19'h0;
        addend = 32'h0;
        casc = 32'h0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        `CHK({resA, coutB, invA, ovfB, unfB}, 67'h0)
        t_sum;
        t_round;
        t_tiny;
        t_flag(16'h7e00, 16'h3c00, 6'b100001);
        t_flag(16'h7c00, 16'h0000, 6'b100101);
        t_flag(16'h0000, 16'h3c00, 6'b001000);
        t_flag(16'h7c00, 16'h3c00, 6'b010000);
        t_flag(16'h7bff, 16'h7bff, 6'b000010);
        t_accum;
        results;
    end

    // The whole run needs about fifty-five cycles
    initial begin
        repeat (2000) @(posedge clk);
        numErrors = numErrors + 1;
        results;
    end
endmodule // hpdpu_dot_unit_bench
